// ===== plc_fixed_point_logic_unit.v
// Purpose: Execution datapath for fixed-point, contact logic and shifts
// Assumes: One instruction per start pulse, executed in one cycle
// Notes:   Register areas and bit variables live inside this unit
//
// How it works
// - Scaled multiply: Q10 times Q2, rescaled to Q14, into pair.
// - Multiply aligns using fractional counts carried in the instruction.
// - Sources come from general area, parameter area or immediate.
// - Immediate multiplier allowed with register-pair multiplicand.
// - Integer to fixed: read pair, scale to requested count, write pair.
// - Fixed to integer: read pair with given count, write integer pair.
// - Open-contact load sets result to the addressed bit.
// - Closed-contact load sets result to the inverted bit.
// - Series and: result ANDed with the bit.
// - Inverted series and: result ANDed with inverted bit.
// - Block and: AND of two earlier contact-group results.
// - Parallel or: result ORed with the bit.
// - Inverted parallel or: result ORed with inverted bit.
// - Block or: OR of two earlier contact-group results.
// - Xor: result exclusive-ORed with the bit.
// - Inverted xor: result exclusive-ORed with inverted bit.
// - Complement writes the inverted bit back in place.
// - Shifts left and right, signed and unsigned, chosen by opcode.
// - 16-bit left shift of a general register by count, in place.
// - Same left shift works in place on a parameter register.
// - Pairs: low half at lower index, high half at next index.
`include "plc_logic_defs.vh"

module plc_fixed_point_logic_unit #(
  parameter REG_DEPTH  = 64,
  parameter IDX_W      = 6,
  parameter BIT_DEPTH  = 64,
  parameter BIT_IDX_W  = 6
) (
  input  wire                 clk,
  input  wire                 sys_rst,
  input  wire                 instr_valid,
  input  wire [4:0]           opcode,
  input  wire [1:0]           src_a_area,
  input  wire [IDX_W-1:0]     src_a_index,
  input  wire [31:0]          src_a_imm,
  input  wire [1:0]           src_b_area,
  input  wire [IDX_W-1:0]     src_b_index,
  input  wire [31:0]          src_b_imm,
  input  wire [IDX_W-1:0]     dest_index,
  input  wire [5:0]           frac_result,
  input  wire [5:0]           frac_a,
  input  wire [5:0]           frac_b,
  input  wire [3:0]           shift_count,
  input  wire [BIT_IDX_W-1:0] bit_index,
  input  wire                 load_wr_en,
  input  wire [1:0]           load_area,
  input  wire [IDX_W-1:0]     load_index,
  input  wire [15:0]          load_data,
  input  wire                 bit_wr_en,
  input  wire [BIT_IDX_W-1:0] bit_wr_index,
  input  wire                 bit_wr_data,
  input  wire [1:0]           peek_area,
  input  wire [IDX_W-1:0]     peek_index,
  input  wire [BIT_IDX_W-1:0] peek_bit_index,
  output reg                  done,
  output reg                  logic_result,
  output reg                  saved_result,
  output reg  [31:0]          result_value,
  output reg  [15:0]          peek_data,
  output reg                  peek_bit
);

  // ****************************************
  // Storage
  // ****************************************
  reg [15:0] general_area [0:REG_DEPTH-1];
  reg [15:0] param_area   [0:REG_DEPTH-1];
  reg        bit_vars     [0:BIT_DEPTH-1];

  integer i;

  // ****************************************
  // Operand fetch
  // ****************************************
  function [IDX_W-1:0] next_idx;
    input [IDX_W-1:0] idx;
    begin
      next_idx = idx + {{(IDX_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // ****************************************
  // Operand words
  // ****************************************
  // Words read by continuous assignment, not inside a function,
  // so a write to an addressed cell wakes every reader at once
  // pair layout
  wire [15:0] gen_a_lo = general_area[src_a_index];
  wire [15:0] gen_a_hi = general_area[next_idx(src_a_index)];
  wire [15:0] par_a_lo = param_area[src_a_index];
  wire [15:0] par_a_hi = param_area[next_idx(src_a_index)];
  wire [15:0] gen_b_lo = general_area[src_b_index];
  wire [15:0] gen_b_hi = general_area[next_idx(src_b_index)];
  wire [15:0] par_b_lo = param_area[src_b_index];
  wire [15:0] par_b_hi = param_area[next_idx(src_b_index)];
  wire [15:0] gen_peek = general_area[peek_index];
  wire [15:0] par_peek = param_area[peek_index];

  function [31:0] pick_pair;
    input [1:0]  area;
    input [15:0] gen_lo;
    input [15:0] gen_hi;
    input [15:0] par_lo;
    input [15:0] par_hi;
    input [31:0] imm;
    begin
      case (area)
        `AREA_GENERAL: begin
          pick_pair = {gen_hi, gen_lo};
        end
        `AREA_PARAMETER: begin
          pick_pair = {par_hi, par_lo};
        end
        default: begin
          pick_pair = imm;
        end
      endcase
    end
  endfunction

  // Immediate area on a word operand falls back to the general area
  function [15:0] pick_word;
    input [1:0]  area;
    input [15:0] gen;
    input [15:0] par;
    begin
      if (area == `AREA_PARAMETER) begin
        pick_word = par;
      end else begin
        pick_word = gen;
      end
    end
  endfunction

  // ****************************************
  // Arithmetic
  // ****************************************
  wire [31:0] op_a = pick_pair(src_a_area, gen_a_lo, gen_a_hi,
                               par_a_lo, par_a_hi, src_a_imm);
  wire [31:0] op_b = pick_pair(src_b_area, gen_b_lo, gen_b_hi,
                               par_b_lo, par_b_hi, src_b_imm);

  // Full 64-bit product so no precision is lost before realignment
  wire signed [63:0] product = $signed(op_a) * $signed(op_b);
  wire [6:0] frac_in = {1'b0, frac_a} + {1'b0, frac_b};
  wire [6:0] frac_out = {1'b0, frac_result};

  reg  [31:0] next_result;
  reg  [63:0] scaled;
  reg  [15:0] shift_src;
  reg  [15:0] shift_out;

  always @* begin
    scaled = 64'h0000_0000_0000_0000;
    next_result = `RST_WIDE;
    case (opcode)
      `OP_SCALED_MULTIPLY: begin
        if (frac_in >= frac_out) begin
          scaled = product >>> (frac_in - frac_out);
        end else begin
          scaled = product <<< (frac_out - frac_in);
        end
        // Only the low 32 bits are kept, so an out-of-range result wraps
        next_result = scaled[31:0];
      end
      `OP_INT_TO_FIXED: begin
        next_result = op_a << frac_result;
      end
      `OP_FIXED_TO_INT: begin
        next_result = $signed(op_a) >>> frac_result;
      end
      default: begin
        next_result = `RST_WIDE;
      end
    endcase
  end

  // ****************************************
  // Shifter
  // ****************************************
  always @* begin
    shift_src = pick_word(src_a_area, gen_a_lo, par_a_lo);
    case (opcode)
      `OP_UNSIGNED_SHIFT_LEFT: begin
        shift_out = shift_src << shift_count;
      end
      `OP_UNSIGNED_SHIFT_RIGHT: begin
        shift_out = shift_src >> shift_count;
      end
      `OP_SIGNED_SHIFT_LEFT: begin
        shift_out = $signed(shift_src) <<< shift_count;
      end
      `OP_SIGNED_SHIFT_RIGHT: begin
        shift_out = $signed(shift_src) >>> shift_count;
      end
      default: begin
        shift_out = shift_src;
      end
    endcase
  end

  wire is_shift = (opcode == `OP_UNSIGNED_SHIFT_LEFT) ||
                  (opcode == `OP_UNSIGNED_SHIFT_RIGHT) ||
                  (opcode == `OP_SIGNED_SHIFT_LEFT) ||
                  (opcode == `OP_SIGNED_SHIFT_RIGHT);
  wire is_arith = (opcode == `OP_SCALED_MULTIPLY) ||
                  (opcode == `OP_INT_TO_FIXED) ||
                  (opcode == `OP_FIXED_TO_INT);

  // ****************************************
  // Contact logic
  // ****************************************
  wire contact = bit_vars[bit_index];
  reg  next_logic;
  reg  next_saved;

  always @* begin
    next_logic = logic_result;
    next_saved = saved_result;
    case (opcode)
      `OP_LOAD_OPEN_CONTACT: begin
        next_saved = logic_result;
        next_logic = contact;
      end
      `OP_LOAD_CLOSED_CONTACT: begin
        next_saved = logic_result;
        next_logic = ~contact;
      end
      `OP_SERIES_AND: begin
        next_logic = logic_result & contact;
      end
      `OP_SERIES_AND_INVERTED: begin
        next_logic = logic_result & ~contact;
      end
      `OP_BLOCK_AND: begin
        next_logic = logic_result & saved_result;
      end
      `OP_PARALLEL_OR: begin
        next_logic = logic_result | contact;
      end
      `OP_PARALLEL_OR_INVERTED: begin
        next_logic = logic_result | ~contact;
      end
      `OP_BLOCK_OR: begin
        next_logic = logic_result | saved_result;
      end
      `OP_XOR: begin
        next_logic = logic_result ^ contact;
      end
      `OP_XOR_INVERTED: begin
        next_logic = logic_result ^ ~contact;
      end
      default: begin
        next_logic = logic_result;
      end
    endcase
  end

  // ****************************************
  // State update
  // ****************************************
  // Loader writes lose to an instruction writing the same cell
  always @(posedge clk) begin
    if (sys_rst) begin
      for (i = 0; i < REG_DEPTH; i = i + 1) begin
        general_area[i] <= `RST_WORD;
        param_area[i]   <= `RST_WORD;
      end
      for (i = 0; i < BIT_DEPTH; i = i + 1) begin
        bit_vars[i] <= `RST_BIT;
      end
      done         <= 1'b0;
      logic_result <= `RST_BIT;
      saved_result <= `RST_BIT;
      result_value <= `RST_WIDE;
      peek_data    <= `RST_WORD;
      peek_bit     <= `RST_BIT;
    end else begin
      done      <= instr_valid;
      peek_data <= pick_word(peek_area, gen_peek, par_peek);
      peek_bit  <= bit_vars[peek_bit_index];
      if (load_wr_en) begin
        if (load_area == `AREA_PARAMETER) begin
          param_area[load_index] <= load_data;
        end else begin
          general_area[load_index] <= load_data;
        end
      end
      if (bit_wr_en) begin
        bit_vars[bit_wr_index] <= bit_wr_data;
      end
      if (instr_valid) begin
        logic_result <= next_logic;
        saved_result <= next_saved;
        if (is_arith) begin
          result_value <= next_result;
          general_area[dest_index]           <= next_result[15:0];
          general_area[next_idx(dest_index)] <= next_result[31:16];
        end
        if (is_shift) begin
          result_value <= {16'h0000, shift_out};
          if (src_a_area == `AREA_PARAMETER) begin
            param_area[src_a_index] <= shift_out;
          end else begin
            general_area[src_a_index] <= shift_out;
          end
        end
        if (opcode == `OP_BIT_COMPLEMENT) begin
          bit_vars[bit_index] <= ~contact;
        end
      end
    end
  end

endmodule // plc_fixed_point_logic_unit

// ===== plc_logic_defs.vh
// Purpose: Shared constants for the logic-controller execution unit
// Assumes: Included by bare name from the design file
// Notes:   Opcodes and area codes are local encodings of this unit
`ifndef PLC_LOGIC_DEFS_VH
`define PLC_LOGIC_DEFS_VH

// ****************************************
// Operation codes
// ****************************************
`define OP_NOP                  5'h00
`define OP_SCALED_MULTIPLY      5'h01
`define OP_INT_TO_FIXED         5'h02
`define OP_FIXED_TO_INT         5'h03
`define OP_LOAD_OPEN_CONTACT    5'h04
`define OP_LOAD_CLOSED_CONTACT  5'h05
`define OP_SERIES_AND           5'h06
`define OP_SERIES_AND_INVERTED  5'h07
`define OP_BLOCK_AND            5'h08
`define OP_PARALLEL_OR          5'h09
`define OP_PARALLEL_OR_INVERTED 5'h0A
`define OP_BLOCK_OR             5'h0B
`define OP_XOR                  5'h0C
`define OP_XOR_INVERTED         5'h0D
`define OP_BIT_COMPLEMENT       5'h0E
`define OP_UNSIGNED_SHIFT_LEFT  5'h10
`define OP_UNSIGNED_SHIFT_RIGHT 5'h11
`define OP_SIGNED_SHIFT_LEFT    5'h12
`define OP_SIGNED_SHIFT_RIGHT   5'h13

// ****************************************
// Operand areas
// ****************************************
`define AREA_GENERAL            2'h0
`define AREA_PARAMETER          2'h1
`define AREA_IMMEDIATE          2'h2

// ****************************************
// Reset values
// ****************************************
`define RST_WORD                16'h0000
`define RST_WIDE                32'h0000_0000
`define RST_BIT                 1'b0

`endif

// ===== plc_unit_props.sv
// Purpose: Port-level checks for the fixed-point and contact unit
// Assumes: One clock, synchronous active-high reset
// Notes:   Bit store is internal, so contact checks are relational
`include "plc_logic_defs.vh"
module plc_unit_props (
  input logic        clk,
  input logic        sys_rst,
  input logic        instr_valid,
  input logic [4:0]  opcode,
  input logic [1:0]  src_a_area,
  input logic [31:0] src_a_imm,
  input logic [1:0]  src_b_area,
  input logic [31:0] src_b_imm,
  input logic [5:0]  frac_result,
  input logic [5:0]  frac_a,
  input logic [5:0]  frac_b,
  input logic        done,
  input logic        logic_result,
  input logic        saved_result,
  input logic [31:0] result_value
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  function automatic logic [31:0] scaled_multiply(input logic [31:0] a, b,
                                       input logic [5:0] fa, fb, fr);
    logic signed [63:0] p;
    int                 d;
    p = $signed(a) * $signed(b);
    d = int'(fa) + int'(fb) - int'(fr);
    if (d >= 0) return 32'(p >>> d);
    return 32'(p <<< (-d));
  endfunction
  // Only immediates are visible here, register sources are unseen
  wire        imm_ab  = src_a_area == `AREA_IMMEDIATE &&
                        src_b_area == `AREA_IMMEDIATE;
  wire [31:0] mul_exp = scaled_multiply(src_a_imm, src_b_imm, frac_a, frac_b,
                             frac_result);
  wire [31:0] f2i_exp = 32'($signed(src_a_imm) >>> frac_result);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_mul_imm;
    instr_valid && opcode == `OP_SCALED_MULTIPLY && imm_ab
      |=> result_value == $past(mul_exp);
  endproperty
  a_mul_imm: assert property (p_mul_imm)
    else $error("scaled product wrong");
  property p_f2i_imm;
    instr_valid && opcode == `OP_FIXED_TO_INT &&
      src_a_area == `AREA_IMMEDIATE |=> result_value == $past(f2i_exp);
  endproperty
  a_f2i_imm: assert property (p_f2i_imm)
    else $error("fixed to integer wrong");
  property p_load_saves;
    instr_valid && opcode inside {`OP_LOAD_OPEN_CONTACT,
      `OP_LOAD_CLOSED_CONTACT} |=> saved_result == $past(logic_result);
  endproperty
  a_load_saves: assert property (p_load_saves)
    else $error("load did not save result");
  property p_and_zero;
    instr_valid && !logic_result && opcode inside {`OP_SERIES_AND,
      `OP_SERIES_AND_INVERTED} |=> !logic_result;
  endproperty
  a_and_zero: assert property (p_and_zero)
    else $error("and raised a false result");
  property p_or_one;
    instr_valid && logic_result && opcode inside {`OP_PARALLEL_OR,
      `OP_PARALLEL_OR_INVERTED} |=> logic_result;
  endproperty
  a_or_one: assert property (p_or_one)
    else $error("or dropped a true result");
  property p_block_and;
    instr_valid && opcode == `OP_BLOCK_AND
      |=> logic_result == $past(logic_result && saved_result);
  endproperty
  a_block_and: assert property (p_block_and)
    else $error("block and wrong");
  property p_block_or;
    instr_valid && opcode == `OP_BLOCK_OR
      |=> logic_result == $past(logic_result || saved_result);
  endproperty
  a_block_or: assert property (p_block_or)
    else $error("block or wrong");
  property p_arith_hold;
    instr_valid && opcode == `OP_SCALED_MULTIPLY
      |=> $stable(logic_result) && $stable(saved_result) && done;
  endproperty
  a_arith_hold: assert property (p_arith_hold)
    else $error("arithmetic touched logic result");
  property p_shift_word;
    instr_valid && opcode inside {`OP_UNSIGNED_SHIFT_LEFT,
      `OP_SIGNED_SHIFT_RIGHT} |=> result_value[31:16] == 16'h0000;
  endproperty
  a_shift_word: assert property (p_shift_word)
    else $error("shift result not a word");
  property p_reset;
    disable iff (1'b0)
      sys_rst |=> !done && !logic_result && result_value == 32'h0000_0000;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
  c_mul: cover property (instr_valid && opcode == `OP_SCALED_MULTIPLY);
  c_band: cover property (instr_valid && opcode == `OP_BLOCK_AND);
  c_shift: cover property (instr_valid && opcode == `OP_SIGNED_SHIFT_RIGHT);
endmodule // plc_unit_props

bind plc_fixed_point_logic_unit plc_unit_props i_plc_unit_props (
  .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
  .opcode(opcode), .src_a_area(src_a_area), .src_a_imm(src_a_imm),
  .src_b_area(src_b_area), .src_b_imm(src_b_imm),
  .frac_result(frac_result), .frac_a(frac_a), .frac_b(frac_b),
  .done(done), .logic_result(logic_result),
  .saved_result(saved_result), .result_value(result_value));

// ===== tb.sv
// Purpose: Directed bench for the fixed-point and contact unit
// Assumes: Storage preloaded and read back through loader and peek
// Notes:   Expected values worked out by hand from the operands
`include "plc_logic_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, sys_rst = 1, instr_valid = 0, load_wr_en = 0;
  logic        bit_wr_en = 0, bit_wr_data = 0;
  logic [4:0]  opcode = 0;
  logic [1:0]  src_a_area = 0, src_b_area = 0, load_area = 0;
  logic [1:0]  peek_area = 0;
  logic [5:0]  src_a_index = 0, src_b_index = 0, dest_index = 0;
  logic [5:0]  load_index = 0, frac_result = 0, frac_a = 0, frac_b = 0;
  logic [5:0]  bit_index = 0, bit_wr_index = 0, peek_index = 0;
  logic [5:0]  peek_bit_index = 0;
  logic [31:0] src_a_imm = 0, src_b_imm = 0;
  logic [3:0]  shift_count = 0;
  logic [15:0] load_data = 0, peek_data;
  logic        done, logic_result, saved_result, peek_bit;
  logic [31:0] result_value;
  int          fails = 0, n_tests = 0;
  always #5 clk = ~clk;
  plc_fixed_point_logic_unit i_plc_fixed_point_logic_unit (
    .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .opcode(opcode), .src_a_area(src_a_area), .src_a_index(src_a_index),
    .src_a_imm(src_a_imm), .src_b_area(src_b_area),
    .src_b_index(src_b_index), .src_b_imm(src_b_imm),
    .dest_index(dest_index), .frac_result(frac_result), .frac_a(frac_a),
    .frac_b(frac_b), .shift_count(shift_count), .bit_index(bit_index),
    .load_wr_en(load_wr_en), .load_area(load_area),
    .load_index(load_index), .load_data(load_data),
    .bit_wr_en(bit_wr_en), .bit_wr_index(bit_wr_index),
    .bit_wr_data(bit_wr_data), .peek_area(peek_area),
    .peek_index(peek_index), .peek_bit_index(peek_bit_index),
    .done(done), .logic_result(logic_result),
    .saved_result(saved_result), .result_value(result_value),
    .peek_data(peek_data), .peek_bit(peek_bit));
  // ****************************************
  // Bus tasks
  // ****************************************
  task check(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_word(input logic [1:0] a, input logic [5:0] i,
               input logic [15:0] d);
    @(posedge clk);
    load_wr_en <= 1; load_area <= a; load_index <= i; load_data <= d;
    @(posedge clk);
    load_wr_en <= 0;
  endtask
  task wr_pair(input logic [1:0] a, input logic [5:0] i,
               input logic [31:0] d);
    wr_word(a, i, d[15:0]);
    wr_word(a, i + 6'h01, d[31:16]);
  endtask
  task wr_bit(input logic [5:0] i, input logic d);
    @(posedge clk);
    bit_wr_en <= 1; bit_wr_index <= i; bit_wr_data <= d;
    @(posedge clk);
    bit_wr_en <= 0;
  endtask
  // Peek is registered, so one spare edge before sampling
  task rd_word(input logic [1:0] a, input logic [5:0] i,
               output logic [15:0] v);
    @(posedge clk);
    peek_area <= a; peek_index <= i; peek_bit_index <= i;
    repeat (2) @(posedge clk);
    #1 v = peek_data;
  endtask
  task rd_pair(input logic [1:0] a, input logic [5:0] i,
               output logic [31:0] v);
    logic [15:0] lo, hi;
    rd_word(a, i, lo);
    rd_word(a, i + 6'h01, hi);
    v = {hi, lo};
  endtask
  task exec(input logic [4:0] op);
    @(posedge clk);
    instr_valid <= 1; opcode <= op;
    @(posedge clk);
    instr_valid <= 0;
    #1;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_arith;
    logic [31:0] v;
    wr_pair(`AREA_GENERAL, 6'h01, 32'h0000_0E00);
    wr_pair(`AREA_GENERAL, 6'h03, 32'hFFFF_FFF7);
    wr_pair(`AREA_PARAMETER, 6'h03, 32'h0001_0002);
    @(posedge clk);
    src_a_index <= 6'h01; src_b_index <= 6'h03; dest_index <= 6'h05;
    frac_result <= 6'h0E; frac_a <= 6'h0A; frac_b <= 6'h02;
    exec(`OP_SCALED_MULTIPLY);
    check(result_value, 32'hFFFE_0800);
    rd_pair(`AREA_GENERAL, 6'h05, v);
    check(v, 32'hFFFE_0800);
    @(posedge clk);
    src_a_area <= `AREA_IMMEDIATE; src_a_imm <= 32'h0000_0E00;
    src_b_area <= `AREA_PARAMETER; frac_result <= 6'h0A;
    exec(`OP_SCALED_MULTIPLY);
    check(result_value, 32'h0380_0700);
    @(posedge clk);
    src_b_area <= `AREA_IMMEDIATE; src_b_imm <= 32'hFFFF_FFF7;
    frac_result <= 6'h0E;
    exec(`OP_SCALED_MULTIPLY);
    check(result_value, 32'hFFFE_0800);
    wr_pair(`AREA_GENERAL, 6'h01, 32'h0000_0003);
    @(posedge clk);
    src_a_area <= `AREA_GENERAL; dest_index <= 6'h03;
    exec(`OP_INT_TO_FIXED);
    rd_pair(`AREA_GENERAL, 6'h03, v);
    check(v, 32'h0000_C000);
    @(posedge clk);
    src_a_area <= `AREA_IMMEDIATE; src_a_imm <= 32'hFFFF_0000;
    exec(`OP_FIXED_TO_INT);
    check(result_value, 32'hFFFF_FFFC);
    $display("t_arith finished");
  endtask
  task t_logic;
    logic [4:0]  ops [0:15];
    logic [15:0] ex, b2;
    logic [15:0] w;
    ops = '{`OP_LOAD_OPEN_CONTACT, `OP_SERIES_AND, `OP_PARALLEL_OR_INVERTED,
            `OP_SERIES_AND_INVERTED, `OP_PARALLEL_OR, `OP_XOR,
            `OP_XOR_INVERTED, `OP_LOAD_CLOSED_CONTACT, `OP_BLOCK_OR,
            `OP_LOAD_CLOSED_CONTACT, `OP_SERIES_AND, `OP_BLOCK_AND,
            `OP_SERIES_AND_INVERTED, `OP_PARALLEL_OR,
            `OP_PARALLEL_OR_INVERTED, `OP_BLOCK_AND};
    ex = 16'hAAC7;
    b2 = 16'h6268;
    wr_bit(6'h01, 1'b1);
    wr_bit(6'h02, 1'b0);
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      bit_index <= b2[15-k] ? 6'h02 : 6'h01;
      exec(ops[k]);
      check(logic_result, ex[15-k]);
    end
    @(posedge clk);
    bit_index <= 6'h01;
    exec(`OP_BIT_COMPLEMENT);
    rd_word(`AREA_GENERAL, 6'h01, w);
    check(peek_bit, 1'b0);
    $display("t_logic finished");
  endtask
  task t_shift;
    logic [4:0]  ops [0:3];
    logic [63:0] e;
    logic [15:0] w;
    ops = '{`OP_UNSIGNED_SHIFT_LEFT, `OP_UNSIGNED_SHIFT_RIGHT,
            `OP_SIGNED_SHIFT_LEFT, `OP_SIGNED_SHIFT_RIGHT};
    e = 64'h0002_4000_0002_C000;
    for (int k = 0; k < 4; k++) begin
      wr_word(`AREA_GENERAL, 6'h07, 16'h8001);
      @(posedge clk);
      src_a_area <= `AREA_GENERAL; src_a_index <= 6'h07;
      shift_count <= 4'h1;
      exec(ops[k]);
      check(result_value, {16'h0000, e[63-16*k -: 16]});
      rd_word(`AREA_GENERAL, 6'h07, w);
      check(w, e[63-16*k -: 16]);
    end
    wr_word(`AREA_PARAMETER, 6'h04, 16'h1234);
    @(posedge clk);
    src_a_area <= `AREA_PARAMETER; src_a_index <= 6'h04;
    shift_count <= 4'h4;
    exec(`OP_UNSIGNED_SHIFT_LEFT);
    rd_word(`AREA_PARAMETER, 6'h04, w);
    check(w, 16'h2340);
    $display("t_shift finished");
  endtask
  task t_reset;
    logic [31:0] v;
    @(posedge clk);
    bit_index <= 6'h02;
    exec(`OP_LOAD_CLOSED_CONTACT);
    check(logic_result, 1'b1);
    @(posedge clk);
    sys_rst <= 1;
    @(posedge clk);
    sys_rst <= 0;
    #1 check(logic_result, 1'b0);
    rd_pair(`AREA_GENERAL, 6'h05, v);
    check(v, 32'h0000_0000);
    $display("t_reset finished");
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 0;
    t_arith;
    t_logic;
    t_shift;
    t_reset;
    stop_test;
  end
endmodule // tb
